// File: design/fimb_top.sv
// How it works
// - dip enables bits 0..5: phase A/B/C voltage then current
// - aux channel 0..3 dip enables at bits 6..9
// - dip flag high while channel in dip; interrupt only when enabled
// - dip enables read/write by software, reset to zero
// - internal fault enables at bits 1-5, 7, 21, 22
// - converter n status word k enable at bit 9+3n+k, any bit set
// - bit 8 enables interrupt on sample-rate fault
// - bit 6 enables interrupt on converter CRC failure
// - bit 0 enables interrupt on converter initialization fault
// - error enables reset to one; bits 31..23 read zero, not writable
`timescale 1ns/10ps
module fimb_top #(
	parameter int CONVERTERS = 4,
	parameter int WORDS      = 3
) (
	input  wire logic                          clk_sys_i,
	input  wire logic                          rst_i,
	// host register port
	input  wire logic                          reg_wr_i,
	input  wire logic                          reg_rd_i,
	input  wire logic [15:0]                   reg_addr_i,
	input  wire logic [31:0]                   reg_wdata_i,
	output logic      [31:0]                   reg_rdata_o,
	// event sources, same clock domain
	input  wire logic [9:0]                    sag_flag_i,
	input  wire logic [7:0]                    int_fault_i,
	input  wire logic [CONVERTERS*WORDS*16-1:0] conv_status_i,
	input  wire logic                          rate_fault_i,
	input  wire logic                          crc_fault_i,
	input  wire logic                          init_fault_i,
	// masked requests
	output logic                               sag_irq_o,
	output logic                               fault_irq_o,
	output logic                               irq_o
);

	// ==========================================================
	// enable registers
	logic [31:0] dip_en_q;
	logic [31:0] err_en_q;
	logic [9:0]  sag_en;
	logic [22:0] err_src;
	logic        sag_hit;
	logic        err_hit;

	// dip enables: low ten bits only, swell half is another block's
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			dip_en_q <= fimb_pkg::DIP_EN_RESET;
		end else if (reg_wr_i && reg_addr_i == fimb_pkg::DIP_EN_OFFSET) begin
			dip_en_q <= {22'h00_0000, reg_wdata_i[fimb_pkg::DIP_BITS-1:0]};
		end
	end

	// error enables: reserved top bits never stored
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			err_en_q <= fimb_pkg::ERR_EN_RESET;
		end else if (reg_wr_i && reg_addr_i == fimb_pkg::ERR_EN_OFFSET) begin
			err_en_q <= {9'h000, reg_wdata_i[fimb_pkg::ERR_BITS-1:0]};
		end
	end

	// read mux, registered; unmapped words read zero
	// one cycle of latency buys a word that stands until the next read
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				fimb_pkg::DIP_EN_OFFSET: reg_rdata_o <= dip_en_q;
				fimb_pkg::ERR_EN_OFFSET: reg_rdata_o <= err_en_q;
				default:                 reg_rdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// source vector in error enable bit order
	// fixed map, so a mask bit and its source cannot drift apart
	assign sag_en = dip_en_q[fimb_pkg::DIP_BITS-1:0];
	assign err_src[fimb_pkg::ERR_INIT_BIT] = init_fault_i;
	assign err_src[fimb_pkg::ERR_INT_LO_LSB +: 5] = int_fault_i[4:0];
	assign err_src[fimb_pkg::ERR_CRC_BIT]  = crc_fault_i;
	assign err_src[fimb_pkg::ERR_INT5_BIT] = int_fault_i[5];
	assign err_src[fimb_pkg::ERR_RATE_BIT] = rate_fault_i;
	assign err_src[fimb_pkg::ERR_INT6_BIT] = int_fault_i[6];
	assign err_src[fimb_pkg::ERR_INT7_BIT] = int_fault_i[7];

	// one reduction per status word: any set bit counts
	generate
		for (genvar i = 0; i < CONVERTERS*WORDS; i++) begin : g_conv
			assign err_src[fimb_pkg::ERR_CONV_LSB + i] = |conv_status_i[i*16 +: 16];
		end
	endgenerate

	// level flags gated by enables, no latching here
	// clearing a flag upstream drops the request on the next edge
	assign sag_hit = |(sag_flag_i & sag_en);
	assign err_hit = |(err_src & err_en_q[fimb_pkg::ERR_BITS-1:0]);

	// ==========================================================
	// registered requests, one cycle behind the flags
	// the flop costs a cycle but keeps the request pins free of glitches
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sag_irq_o   <= 1'b0;
			fault_irq_o <= 1'b0;
			irq_o       <= 1'b0;
		end else begin
			sag_irq_o   <= sag_hit;
			fault_irq_o <= err_hit;
			irq_o       <= sag_hit | err_hit;
		end
	end

	// ==========================================================
	// named sequences: one host strobe each, two in the write-then-read pairs, address compared in full
	sequence s_dip_write;
		reg_wr_i && reg_addr_i == fimb_pkg::DIP_EN_OFFSET;
	endsequence

	sequence s_err_write;
		reg_wr_i && reg_addr_i == fimb_pkg::ERR_EN_OFFSET;
	endsequence

	sequence s_dip_read;
		reg_rd_i && reg_addr_i == fimb_pkg::DIP_EN_OFFSET;
	endsequence

	sequence s_err_read;
		reg_rd_i && reg_addr_i == fimb_pkg::ERR_EN_OFFSET;
	endsequence

	// a strobe at any other word must leave both masks alone
	sequence s_other_write;
		reg_wr_i && reg_addr_i != fimb_pkg::DIP_EN_OFFSET
			&& reg_addr_i != fimb_pkg::ERR_EN_OFFSET;
	endsequence

	sequence s_other_read;
		reg_rd_i && reg_addr_i != fimb_pkg::DIP_EN_OFFSET
			&& reg_addr_i != fimb_pkg::ERR_EN_OFFSET;
	endsequence

	// write, one quiet cycle, then read back: the usual host pattern
	sequence s_dip_write_then_read;
		s_dip_write ##1 !reg_wr_i ##1 s_dip_read;
	endsequence

	sequence s_err_write_then_read;
		s_err_write ##1 !reg_wr_i ##1 s_err_read;
	endsequence

	// ==========================================================
	// register port checks
	// upper dip bits belong to the swell half, never stored here
	a_dip_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		dip_en_q[31:fimb_pkg::DIP_BITS] == 22'h00_0000)
		else $error("dip enable upper bits not zero");

	// low ten bits take the written word one cycle later
	a_dip_write_store: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_dip_write |=> dip_en_q[fimb_pkg::DIP_BITS-1:0]
			== $past(reg_wdata_i[fimb_pkg::DIP_BITS-1:0]))
		else $error("dip enable write not stored");

	// defined error bits take the written word, reserved ones dropped
	a_err_write_store: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_err_write |=> err_en_q == {9'h000, $past(reg_wdata_i[fimb_pkg::ERR_BITS-1:0])})
		else $error("error enable write not stored");

	// reserved error bits stay zero in the flops themselves
	a_err_upper_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		err_en_q[31:fimb_pkg::ERR_BITS] == 9'h000)
		else $error("error enable upper bits not zero");

	// reserved error bits also read as zero
	a_err_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_err_read |=> reg_rdata_o[31:fimb_pkg::ERR_BITS] == 9'h000)
		else $error("error enable reserved bits read nonzero");

	// a read returns the mask as it stood at the strobe
	a_dip_read_data: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_dip_read |=> reg_rdata_o == $past(dip_en_q))
		else $error("dip enable read data wrong");

	a_err_read_data: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_err_read |=> reg_rdata_o == $past(err_en_q))
		else $error("error enable read data wrong");

	// write then read back sees only the stored bits
	a_dip_readback: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_dip_write_then_read |=> reg_rdata_o
			== {22'h00_0000, $past(reg_wdata_i[fimb_pkg::DIP_BITS-1:0], 3)})
		else $error("dip enable read back wrong");

	a_err_readback: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_err_write_then_read |=> reg_rdata_o
			== {9'h000, $past(reg_wdata_i[fimb_pkg::ERR_BITS-1:0], 3)})
		else $error("error enable read back wrong");

	// unmapped words read zero and ignore writes
	a_other_read_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_other_read |=> reg_rdata_o == 32'h0000_0000)
		else $error("unmapped word read nonzero");

	a_other_write_ignored: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_other_write |=> $stable(dip_en_q) && $stable(err_en_q))
		else $error("unmapped write changed a mask");

	// read data stands until the next read strobe; the host relies on it
	a_rdata_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data changed without a read");

	// ==========================================================
	// interrupt path checks
	// nothing enabled and set on either side means a quiet line
	a_sag_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(sag_flag_i & dip_en_q[fimb_pkg::DIP_BITS-1:0]) == '0 && !err_hit |=> !irq_o)
		else $error("interrupt without enabled source");

	// every error source masked or idle keeps the fault line low
	a_fault_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(err_src & err_en_q[fimb_pkg::ERR_BITS-1:0]) == '0 |=> !fault_irq_o)
		else $error("fault interrupt without enabled source");

	// dip enables all clear, as after reset: the dip line stays low
	a_sag_masked_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		dip_en_q[fimb_pkg::DIP_BITS-1:0] == '0 |=> !sag_irq_o)
		else $error("dip interrupt with all dip enables clear");

	// any enabled dip reaches the shared request
	a_sag_or_fires: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(sag_flag_i & dip_en_q[fimb_pkg::DIP_BITS-1:0]) != '0 |=> irq_o)
		else $error("enabled dip did not raise shared interrupt");

	// phase A voltage, lowest dip bit
	a_phase_sag_fires: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		sag_flag_i[fimb_pkg::DIP_PHASE_LSB]
			&& dip_en_q[fimb_pkg::DIP_PHASE_LSB] |=> sag_irq_o)
		else $error("phase sag did not raise interrupt");

	// first and last aux channel
	a_aux0_sag_fires: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		sag_flag_i[fimb_pkg::DIP_AUX_LSB]
			&& dip_en_q[fimb_pkg::DIP_AUX_LSB] |=> sag_irq_o)
		else $error("aux0 sag did not raise interrupt");

	a_aux_sag_fires: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		sag_flag_i[fimb_pkg::DIP_BITS-1]
			&& dip_en_q[fimb_pkg::DIP_BITS-1] |=> sag_irq_o && irq_o)
		else $error("aux3 sag did not raise interrupt");

	// internal fault sources spread over four fields of the error enables, eight bit positions
	a_int_lo_fires: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		int_fault_i[0] && err_en_q[fimb_pkg::ERR_INT_LO_LSB] |=> fault_irq_o)
		else $error("internal fault 0 did not raise interrupt");

	a_int5_fires: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		int_fault_i[5] && err_en_q[fimb_pkg::ERR_INT5_BIT] |=> fault_irq_o)
		else $error("internal fault 5 did not raise interrupt");

	a_int6_fires: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		int_fault_i[6] && err_en_q[fimb_pkg::ERR_INT6_BIT] |=> fault_irq_o)
		else $error("internal fault 6 did not raise interrupt");

	a_int7_fires: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		int_fault_i[7] && err_en_q[fimb_pkg::ERR_INT7_BIT] |=> fault_irq_o && irq_o)
		else $error("internal fault 7 did not raise interrupt");

	// source 7 alone with its enable clear must stay quiet
	a_int7_masked: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		int_fault_i == 8'h80 && !init_fault_i && !crc_fault_i && !rate_fault_i
		&& conv_status_i == '0 && !err_en_q[fimb_pkg::ERR_INT7_BIT] |=> !fault_irq_o)
		else $error("masked internal fault 7 raised interrupt");

	// converter words: first, one in the middle, last
	a_conv_word0_fires: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		conv_status_i[0 +: 16] != 16'h0000 && err_en_q[fimb_pkg::ERR_CONV_LSB] |=> fault_irq_o)
		else $error("converter 0 word 0 did not raise interrupt");

	a_conv_mid_fires: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		conv_status_i[(WORDS+1)*16 +: 16] != 16'h0000
			&& err_en_q[fimb_pkg::ERR_CONV_LSB + WORDS + 1] |=> fault_irq_o)
		else $error("converter 1 word 1 did not raise interrupt");

	a_conv_word_fires: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		conv_status_i[(CONVERTERS*WORDS-1)*16 +: 16] != 16'h0000
			&& err_en_q[fimb_pkg::ERR_CONV_LSB + CONVERTERS*WORDS - 1] |=> fault_irq_o)
		else $error("converter 3 word 2 did not raise interrupt");

	// the three converter link faults
	a_rate_fault_fires: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		rate_fault_i && err_en_q[fimb_pkg::ERR_RATE_BIT] |=> fault_irq_o)
		else $error("rate fault did not raise interrupt");

	a_crc_fault_fires: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		crc_fault_i && err_en_q[fimb_pkg::ERR_CRC_BIT] |=> fault_irq_o ##0 irq_o)
		else $error("crc fault did not raise interrupt");

	a_init_fault_fires: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		init_fault_i && err_en_q[fimb_pkg::ERR_INIT_BIT] |=> fault_irq_o)
		else $error("init fault did not raise interrupt");

endmodule : fimb_top

// File: design/fimb_pkg.sv
package fimb_pkg;

	// ==========================================================
	// register map, word offsets on the host register port
	localparam logic [15:0] DIP_EN_OFFSET   = 16'h0408;
	localparam logic [15:0] ERR_EN_OFFSET   = 16'h0409;

	// ==========================================================
	// dip enable register layout
	localparam int          DIP_BITS        = 10;
	localparam int          DIP_PHASE_LSB   = 0;
	localparam int          DIP_AUX_LSB     = 6;
	localparam logic [31:0] DIP_EN_RESET    = 32'h0000_0000;

	// ==========================================================
	// error enable register layout
	localparam int          ERR_INIT_BIT    = 0;
	localparam int          ERR_INT_LO_LSB  = 1;
	localparam int          ERR_CRC_BIT     = 6;
	localparam int          ERR_INT5_BIT    = 7;
	localparam int          ERR_RATE_BIT    = 8;
	localparam int          ERR_CONV_LSB    = 9;
	localparam int          ERR_INT6_BIT    = 21;
	localparam int          ERR_INT7_BIT    = 22;
	localparam int          ERR_BITS        = 23;
	localparam logic [31:0] ERR_EN_RESET    = 32'h007F_FFFF;

endpackage : fimb_pkg

// File: bench/test_fault_interrupt_mask_bank.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s expected %h seen %h", n, e, a); end end
module test_fault_interrupt_mask_bank;
	// ==========================================================
	// stimulus rows: enables, flags, misc {conv,rate,crc,init}, expected {fault,sag}
	typedef struct packed {
		logic [31:0] de;
		logic [31:0] ee;
		logic [9:0]  sf;
		logic [7:0]  fi;
		logic [3:0]  ms;
		logic [3:0]  cw;
		logic [1:0]  ex;
	} fimb_row_s;
	logic         clk_sys_i, rst_i, reg_wr_i, reg_rd_i, rate_fault_i, crc_fault_i, init_fault_i;
	logic         sag_irq_o, fault_irq_o, irq_o;
	logic [15:0]  reg_addr_i;
	logic [31:0]  reg_wdata_i, reg_rdata_o;
	logic [9:0]   sag_flag_i;
	logic [7:0]   int_fault_i;
	logic [191:0] conv_status_i;
	int           n_mismatch = 0, n_tests = 0, cyc = 0;
	fimb_row_s    rows [17];

	fimb_top i_fimb_top (.clk_sys_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
		.reg_rdata_o, .sag_flag_i, .int_fault_i, .conv_status_i, .rate_fault_i,
		.crc_fault_i, .init_fault_i, .sag_irq_o, .fault_irq_o, .irq_o);

	// ==========================================================
	// host port cycles, one gap cycle between strobes
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_wr_i <= 1'h1; reg_addr_i <= a; reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'h0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		reg_rd_i <= 1'h1; reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'h0;
		#1;
		`CHK("rdata", e, reg_rdata_o)
	endtask : rd
	task automatic print_verdict();
		$display("mismatches %0d, checks %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict

	// clock and hang guard; whole run is well under 1000 cycles
	initial begin
		clk_sys_i = 1'h0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 3000) begin n_mismatch++; print_verdict(); end
	end

	initial begin
		rows = '{'{32'h0000_0001, 32'h0, 10'h001, 8'h00, 4'h0, 4'h0, 2'h1},
			'{32'h0000_03FE, 32'h0, 10'h001, 8'h00, 4'h0, 4'h0, 2'h0},
			'{32'h0000_0200, 32'h0, 10'h200, 8'h00, 4'h0, 4'h0, 2'h1},
			'{32'h0, 32'h0000_0002, 10'h000, 8'h01, 4'h0, 4'h0, 2'h2},
			'{32'h0, 32'h0040_0000, 10'h000, 8'h80, 4'h0, 4'h0, 2'h2},
			'{32'h0, 32'h0020_0000, 10'h000, 8'h80, 4'h0, 4'h0, 2'h0},
			'{32'h0, 32'h0010_0000, 10'h000, 8'h00, 4'h8, 4'hB, 2'h2},
			'{32'h0, 32'h0000_0200, 10'h000, 8'h00, 4'h8, 4'hB, 2'h0},
			'{32'h0, 32'h0000_0100, 10'h000, 8'h00, 4'h4, 4'h0, 2'h2},
			'{32'h0, 32'h0000_0040, 10'h000, 8'h00, 4'h2, 4'h0, 2'h2},
			'{32'h0, 32'h0000_0001, 10'h000, 8'h00, 4'h1, 4'h0, 2'h2},
			'{32'h0000_0020, 32'h0, 10'h020, 8'h00, 4'h0, 4'h0, 2'h1},
			'{32'h0000_0040, 32'h0, 10'h040, 8'h00, 4'h0, 4'h0, 2'h1},
			'{32'h0, 32'h0000_0080, 10'h000, 8'h20, 4'h0, 4'h0, 2'h2},
			'{32'h0, 32'h0020_0000, 10'h000, 8'h40, 4'h0, 4'h0, 2'h2},
			'{32'h0, 32'h0000_2000, 10'h000, 8'h00, 4'h8, 4'h4, 2'h2},
			'{32'h0, 32'h0000_0200, 10'h000, 8'h00, 4'h8, 4'h0, 2'h2}};
		{reg_wr_i, reg_rd_i, rate_fault_i, crc_fault_i, init_fault_i} = 5'h00;
		{reg_addr_i, reg_wdata_i, sag_flag_i, int_fault_i, conv_status_i} = '0;
		rst_i = 1'h1;
		repeat (10) @(posedge clk_sys_i);
		rst_i <= 1'h0;
		// ======================================================
		// reset values, write masking, unmapped offset
		rd(16'h0408, 32'h0000_0000);
		rd(16'h0409, 32'h007F_FFFF);
		wr(16'h0408, 32'hFFFF_FFFF);
		wr(16'h0409, 32'hFFFF_FFFF);
		wr(16'h040A, 32'h0000_0000);
		rd(16'h0408, 32'h0000_03FF);
		rd(16'h0409, 32'h007F_FFFF);
		rd(16'h040A, 32'h0000_0000);
		// ======================================================
		// one source per row; flags are levels, so clear after each
		foreach (rows[i]) begin
			wr(16'h0408, rows[i].de);
			wr(16'h0409, rows[i].ee);
			sag_flag_i <= rows[i].sf;
			int_fault_i <= rows[i].fi;
			{rate_fault_i, crc_fault_i, init_fault_i} <= rows[i].ms[2:0];
			conv_status_i <= rows[i].ms[3] ? 192'(16'h8000) << (rows[i].cw * 16) : '0;
			repeat (2) @(posedge clk_sys_i);
			#1;
			`CHK("irq", {|rows[i].ex, rows[i].ex}, {irq_o, fault_irq_o, sag_irq_o})
			{sag_flag_i, int_fault_i, conv_status_i} <= '0;
			{rate_fault_i, crc_fault_i, init_fault_i} <= 3'h0;
		end
		// ======================================================
		// write then read back; leaves both masks off their reset values
		wr(16'h0408, 32'hABCD_E2A5);
		rd(16'h0408, 32'h0000_02A5);
		wr(16'h0409, 32'hFFAA_5555);
		rd(16'h0409, 32'h002A_5555);
		// ======================================================
		// reset in mid-run: outputs low, error enables back on
		@(posedge clk_sys_i);
		rst_i <= 1'h1;
		int_fault_i <= 8'h10;
		repeat (2) @(posedge clk_sys_i);
		#1;
		`CHK("irq in reset", 3'h0, {irq_o, fault_irq_o, sag_irq_o})
		rst_i <= 1'h0;
		repeat (2) @(posedge clk_sys_i);
		#1;
		`CHK("irq after reset", 3'h6, {irq_o, fault_irq_o, sag_irq_o})
		rd(16'h0408, 32'h0000_0000);
		rd(16'h0409, 32'h007F_FFFF);
		print_verdict();
	end
endmodule : test_fault_interrupt_mask_bank
